// ===== logic/cfs_pkg.sv
/*
 Constants for the chirp frame sequencer: register map, profile word
 layout, reset values and timing counts. Assumes a 25 MHz system clock.
*/
package cfs_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int US_PER_S = 1000000;
   localparam int TICK_US = 1; // Sequencer time step in microseconds
   localparam int US_CYC = (CLK_HZ / US_PER_S) * TICK_US;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STATUS = 12'h004;
   localparam logic [11:0] A_LEAD = 12'h008;
   localparam logic [11:0] A_PERIODS = 12'h00c;
   localparam logic [11:0] A_NCLUS = 12'h010;
   localparam logic [11:0] A_IRQ_STAT = 12'h014;
   localparam logic [11:0] A_IRQ_MASK = 12'h018;
   localparam logic [11:0] A_THR_LO = 12'h01c;
   localparam logic [11:0] A_THR_HI = 12'h020;
   localparam logic [11:0] A_CLUS_BASE = 12'h100;
   localparam logic [11:0] A_PROF_BASE = 12'h800;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_START = 0;
   localparam int CTRL_INF = 1;
   localparam int CTRL_EXT_EN = 2;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_RAMP = 1;
   localparam int IRQ_IGN = 2;
   localparam int CLUS_REP_LSB = 8; // Cluster word: profile [4:0], reps [20:8]
   // ----------------------------------------------------------------
   // Profile word indices, 16 words per profile
   // ----------------------------------------------------------------
   localparam int PW = 16;
   localparam int P_FLO = 0;
   localparam int P_FHI = 1;
   localparam int P_FFIN = 2;
   localparam int P_SUP = 3;
   localparam int P_SDN = 4;
   localparam int P_DUP = 5;
   localparam int P_DHI = 6;
   localparam int P_DDN = 7;
   localparam int P_DLO = 8;
   localparam int P_LEAK = 9;
   localparam int P_GLO = 10;
   localparam int P_GHI = 11;
   localparam int P_GFIN = 12;
   localparam int P_PD = 13; // Start [15:0], end [31:16], in microseconds
   localparam int P_LIN = 14;
   // ----------------------------------------------------------------
   // Reset values and leaker codes
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0004;
   localparam logic [11:0] PERIODS_RST = 12'h001;
   localparam logic [4:0] NCLUS_RST = 5'h01;
   localparam logic [1:0] LEAK_ZERO = 2'h0;
   localparam logic [1:0] LEAK_POS = 2'h1;
   localparam logic [1:0] LEAK_NEG = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE, ST_LEAD, ST_CLUS, ST_LOAD, ST_UP, ST_HIGH, ST_DOWN, ST_LOW
   } cfs_state_e;
endpackage

// ===== logic/cfs_prof_ram.sv
/*
 Profile memory: one write port, one read port with registered data.
 Assumes a single clock shared by both ports.
*/
`timescale 1ns/100ps
module cfs_prof_ram #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 448,
   parameter int AW = 9
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   if (DEPTH > (1 << AW)) begin : g_chk
      $error("cfs_prof_ram: depth exceeds address range");
   end

   // Write port, out-of-range writes dropped
   always_ff @(posedge clk) begin
      if (we && (int'(waddr) < DEPTH)) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read
   always_ff @(posedge clk) begin
      rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : '0;
   end
endmodule // cfs_prof_ram

// ===== logic/cfs_seq.sv
/*
 Chirp frame sequencer: lead segment, periods of clusters, chirps built
 from stored profiles, ramp check and interrupt. Registers on Avalon-MM.
 Assumes sync_pin is asynchronous and ramp_meas comes from clk logic.
*/
// Added by the designer: the Avalon-MM register port and the placing of the registers.
// What this block does
// - Starts on trigger pin or bus command.
// - Busy held until whole waveform played.
// - Constant-frequency lead segment for programmed delay.
// - Period repeated 1 to 4095 times, or endlessly.
// - One to 28 clusters per period.
// - Cluster replays chosen profile up to 4096 times.
// - Cluster with zero repeats is skipped.
// - Profile holds three frequencies, two slopes.
// - Four durations time each chirp phase.
// - Leaker sign zero, positive or negative.
// - Feedback gain follows the active frequency.
// - Detection and linear flags within window.
// - Drives the PLL modulator frequency word.
// - Whole frame plays without software help.
// - Up-ramp measurement out of range flags error.
// - Hold phases programmable 0 to 4294967295 us.
`timescale 1ns/100ps
module cfs_seq #(
   parameter int NPROF = 28,
   parameter int NCLUS = 28,
   parameter int MAXREP = 4096,
   parameter int MAXPER = 4095
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic sync_pin,
   input wire logic [31:0] ramp_meas,
   input wire logic ramp_meas_vld,
   output logic busy,
   output logic [31:0] mod_freq_q,
   output logic [15:0] mod_gain_q,
   output logic [1:0] mod_leak_q,
   output logic pd_flag_q,
   output logic lin_flag_q,
   output logic irq
);
   if (NPROF < 1 || NPROF > 32 || NCLUS < 1 || NCLUS > 28 || MAXREP > 8191
       || MAXPER > 4095) begin : g_chk
      $error("cfs_seq: parameter out of range");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   cfs_pkg::cfs_state_e st_q, st_d;
   logic [31:0] ctrl_q, lead_q, thr_lo_q, thr_hi_q;
   logic [11:0] periods_q;
   logic [4:0] nclus_q;
   logic [2:0] irq_stat_q, irq_mask_q;
   logic [20:0] clus_q [NCLUS];
   logic [31:0] prof_q [cfs_pkg::PW];
   logic [31:0] ram_rdata, reg_rdata_q;
   logic [8:0] ram_raddr;
   logic rd_pend_q, rd_mem_q;
   logic s1_q, s2_q, s3_q;
   logic trig, bus_trig, done_evt, ramp_bad;
   logic [4:0] cidx_q, ld_idx_q;
   logic [12:0] rep_q;
   logic [11:0] per_q;
   logic [31:0] rem_q, tmr_val;
   logic tmr_ld;
   logic [4:0] us_cnt_q;
   logic tick;
   logic [15:0] t_us_q;
   logic [4:0] nclus_eff;
   logic [4:0] cur_prof;
   logic [12:0] cur_reps;
   logic wr_ok;

   // True when t lies in [start, end) of a window word
   function automatic logic in_win(input logic [15:0] t, input logic [31:0] w);
      in_win = (t >= w[15:0]) && (t < w[31:16]);
   endfunction

   // ----------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------
   // Writes need no wait; reads wait one cycle for registered data
   assign avs_waitrequest = avs_read & ~rd_pend_q;
   assign avs_readdata = rd_mem_q ? ram_rdata : reg_rdata_q;
   assign wr_ok = avs_write;
   assign bus_trig = wr_ok && avs_address == cfs_pkg::A_CTRL
                     && avs_writedata[cfs_pkg::CTRL_START];

   // Read pending, held off while the sequencer owns the memory port
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_pend_q <= 1'b0;
         rd_mem_q <= 1'b0;
      end else begin
         rd_pend_q <= avs_read & ~rd_pend_q & (st_q != cfs_pkg::ST_LOAD);
         rd_mem_q <= avs_address >= cfs_pkg::A_PROF_BASE;
      end
   end

   // Register read mux, unmapped reads give zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_q <= '0;
      end else begin
         reg_rdata_q <= '0;
         case (avs_address)
            cfs_pkg::A_CTRL: reg_rdata_q <= {ctrl_q[31:1], 1'b0};
            cfs_pkg::A_STATUS: reg_rdata_q <= {cidx_q, 4'h0, 12'(per_q), 7'h0,
                                               3'(st_q), busy};
            cfs_pkg::A_LEAD: reg_rdata_q <= lead_q;
            cfs_pkg::A_PERIODS: reg_rdata_q <= {20'h0, periods_q};
            cfs_pkg::A_NCLUS: reg_rdata_q <= {27'h0, nclus_q};
            cfs_pkg::A_IRQ_STAT: reg_rdata_q <= {29'h0, irq_stat_q};
            cfs_pkg::A_IRQ_MASK: reg_rdata_q <= {29'h0, irq_mask_q};
            cfs_pkg::A_THR_LO: reg_rdata_q <= thr_lo_q;
            cfs_pkg::A_THR_HI: reg_rdata_q <= thr_hi_q;
            default: begin
               if (avs_address >= cfs_pkg::A_CLUS_BASE
                   && avs_address < cfs_pkg::A_CLUS_BASE + 12'(4 * NCLUS)) begin
                  reg_rdata_q <= {11'h0,
                     clus_q[5'(avs_address[11:2] - cfs_pkg::A_CLUS_BASE[11:2])]};
               end
            end
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= cfs_pkg::CTRL_RST;
         lead_q <= '0;
         periods_q <= cfs_pkg::PERIODS_RST;
         nclus_q <= cfs_pkg::NCLUS_RST;
         irq_mask_q <= '0;
         thr_lo_q <= '0;
         thr_hi_q <= '1;
      end else if (wr_ok) begin
         case (avs_address)
            cfs_pkg::A_CTRL: ctrl_q <= avs_writedata;
            cfs_pkg::A_LEAD: lead_q <= avs_writedata;
            cfs_pkg::A_PERIODS: periods_q <= avs_writedata[11:0];
            cfs_pkg::A_NCLUS: nclus_q <= avs_writedata[4:0];
            cfs_pkg::A_IRQ_MASK: irq_mask_q <= avs_writedata[2:0];
            cfs_pkg::A_THR_LO: thr_lo_q <= avs_writedata;
            cfs_pkg::A_THR_HI: thr_hi_q <= avs_writedata;
            default: ;
         endcase
      end
   end

   // Cluster table: profile index and repeat count per cluster
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NCLUS; i++) clus_q[i] <= '0;
      end else if (wr_ok && avs_address >= cfs_pkg::A_CLUS_BASE
                   && avs_address < cfs_pkg::A_CLUS_BASE + 12'(4 * NCLUS)) begin
         clus_q[5'(avs_address[11:2] - cfs_pkg::A_CLUS_BASE[11:2])]
            <= avs_writedata[20:0];
      end
   end

   // Profile storage, read by bus or by the loader
   assign ram_raddr = (st_q == cfs_pkg::ST_LOAD)
                      ? 9'(cur_prof * cfs_pkg::PW + ld_idx_q)
                      : 9'(avs_address[11:2] - cfs_pkg::A_PROF_BASE[11:2]);
   cfs_prof_ram #(.WIDTH(32), .DEPTH(NPROF * cfs_pkg::PW), .AW(9)) u_ram (
      .clk(clk),
      .we(wr_ok && avs_address >= cfs_pkg::A_PROF_BASE),
      .waddr(9'(avs_address[11:2] - cfs_pkg::A_PROF_BASE[11:2])),
      .wdata(avs_writedata),
      .raddr(ram_raddr),
      .rdata(ram_rdata)
   );

   // ----------------------------------------------------------------
   // Trigger and interrupts
   // ----------------------------------------------------------------
   // Two-flop synchroniser plus edge stage for the trigger pin
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= sync_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign trig = bus_trig | (s2_q & ~s3_q & ctrl_q[cfs_pkg::CTRL_EXT_EN]);
   assign ramp_bad = ramp_meas_vld && st_q == cfs_pkg::ST_UP
                     && (ramp_meas < thr_lo_q || ramp_meas > thr_hi_q);

   // Sticky status, write one to clear, a new event wins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~((wr_ok && avs_address == cfs_pkg::A_IRQ_STAT)
                       ? avs_writedata[2:0] : 3'h0))
                       | {trig & busy, ramp_bad, done_evt};
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   assign busy = st_q != cfs_pkg::ST_IDLE;
   assign nclus_eff = (nclus_q == 5'h0) ? 5'h1
                      : (nclus_q > 5'(NCLUS)) ? 5'(NCLUS) : nclus_q;
   assign cur_prof = (clus_q[cidx_q][4:0] >= 5'(NPROF)) ? 5'(NPROF - 1)
                     : clus_q[cidx_q][4:0];
   assign cur_reps = (clus_q[cidx_q][20:8] > 13'(MAXREP)) ? 13'(MAXREP)
                     : clus_q[cidx_q][20:8];
   assign tick = us_cnt_q == 5'(cfs_pkg::US_CYC - 1);

   // Next state and phase timer loads
   always_comb begin
      st_d = st_q;
      tmr_ld = 1'b0;
      tmr_val = '0;
      done_evt = 1'b0;
      case (st_q)
         cfs_pkg::ST_IDLE: begin
            if (trig) begin
               st_d = cfs_pkg::ST_LEAD;
               tmr_ld = 1'b1;
               tmr_val = lead_q;
            end
         end
         cfs_pkg::ST_LEAD: if (rem_q == 0) st_d = cfs_pkg::ST_CLUS;
         cfs_pkg::ST_CLUS: begin
            if (cur_reps != 0) begin
               st_d = cfs_pkg::ST_LOAD;
            end else if (cidx_q + 5'h1 < nclus_eff) begin
               st_d = cfs_pkg::ST_CLUS;
            end else if (ctrl_q[cfs_pkg::CTRL_INF] || per_q + 12'h1 < periods_q) begin
               st_d = cfs_pkg::ST_CLUS;
            end else begin
               st_d = cfs_pkg::ST_IDLE;
               done_evt = 1'b1;
            end
         end
         cfs_pkg::ST_LOAD: begin
            if (ld_idx_q == 5'(cfs_pkg::PW)) begin
               st_d = cfs_pkg::ST_UP;
               tmr_ld = 1'b1;
               tmr_val = prof_q[cfs_pkg::P_DUP];
            end
         end
         cfs_pkg::ST_UP: if (rem_q == 0) begin
            st_d = cfs_pkg::ST_HIGH;
            tmr_ld = 1'b1;
            tmr_val = prof_q[cfs_pkg::P_DHI];
         end
         cfs_pkg::ST_HIGH: if (rem_q == 0) begin
            st_d = cfs_pkg::ST_DOWN;
            tmr_ld = 1'b1;
            tmr_val = prof_q[cfs_pkg::P_DDN];
         end
         cfs_pkg::ST_DOWN: if (rem_q == 0) begin
            st_d = cfs_pkg::ST_LOW;
            tmr_ld = 1'b1;
            tmr_val = prof_q[cfs_pkg::P_DLO];
         end
         cfs_pkg::ST_LOW: if (rem_q == 0) begin
            tmr_ld = 1'b1;
            tmr_val = prof_q[cfs_pkg::P_DUP];
            if (rep_q + 13'h1 < cur_reps) begin
               st_d = cfs_pkg::ST_UP;
            end else if (cidx_q + 5'h1 < nclus_eff
                         || ctrl_q[cfs_pkg::CTRL_INF] || per_q + 12'h1 < periods_q) begin
               st_d = cfs_pkg::ST_CLUS;
            end else begin
               st_d = cfs_pkg::ST_IDLE;
               done_evt = 1'b1;
            end
         end
         default: st_d = cfs_pkg::ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) st_q <= cfs_pkg::ST_IDLE;
      else st_q <= st_d;
   end

   // Microsecond divider and phase timer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         us_cnt_q <= '0;
         rem_q <= '0;
      end else if (tmr_ld) begin
         us_cnt_q <= '0;
         rem_q <= tmr_val;
      end else begin
         us_cnt_q <= tick ? 5'h0 : us_cnt_q + 5'h1;
         if (tick && rem_q != 0) rem_q <= rem_q - 32'h1;
      end
   end

   // Cluster, repeat and period counters, ascending cluster order
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cidx_q <= '0;
         rep_q <= '0;
         per_q <= '0;
      end else if (st_q == cfs_pkg::ST_IDLE) begin
         cidx_q <= '0;
         rep_q <= '0;
         per_q <= '0;
      end else if ((st_q == cfs_pkg::ST_CLUS && st_d == cfs_pkg::ST_CLUS)
                   || (st_q == cfs_pkg::ST_LOW && st_d == cfs_pkg::ST_CLUS)) begin
         rep_q <= '0;
         if (cidx_q + 5'h1 < nclus_eff) begin
            cidx_q <= cidx_q + 5'h1;
         end else begin
            cidx_q <= '0;
            per_q <= (per_q == 12'(MAXPER)) ? 12'h0 : per_q + 12'h1;
         end
      end else if (st_q == cfs_pkg::ST_LOW && st_d == cfs_pkg::ST_UP) begin
         rep_q <= rep_q + 13'h1;
      end
   end

   // Profile loader, one word per cycle behind the registered read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ld_idx_q <= '0;
         for (int i = 0; i < cfs_pkg::PW; i++) prof_q[i] <= '0;
      end else if (st_q == cfs_pkg::ST_LOAD) begin
         ld_idx_q <= ld_idx_q + 5'h1;
         if (ld_idx_q != 0) prof_q[4'(ld_idx_q - 5'h1)] <= ram_rdata;
      end else begin
         ld_idx_q <= '0;
      end
   end

   // Chirp time since ramp start, for the flag windows
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) t_us_q <= '0;
      else if (st_q == cfs_pkg::ST_LOAD || st_q == cfs_pkg::ST_IDLE
               || (st_q == cfs_pkg::ST_LOW && st_d == cfs_pkg::ST_UP)) t_us_q <= '0;
      else if (tick && t_us_q != 16'hffff) t_us_q <= t_us_q + 16'h1;
   end

   // ----------------------------------------------------------------
   // Modulator drive
   // ----------------------------------------------------------------
   // Frequency word: ramps by slope per clock, holds in flat phases
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mod_freq_q <= '0;
      end else begin
         case (st_q)
            cfs_pkg::ST_UP: mod_freq_q <= mod_freq_q + prof_q[cfs_pkg::P_SUP];
            cfs_pkg::ST_HIGH: mod_freq_q <= prof_q[cfs_pkg::P_FHI];
            cfs_pkg::ST_DOWN: mod_freq_q <= mod_freq_q - prof_q[cfs_pkg::P_SDN];
            cfs_pkg::ST_LOW: mod_freq_q <= done_evt ? prof_q[cfs_pkg::P_FFIN]
                                           : prof_q[cfs_pkg::P_FLO];
            cfs_pkg::ST_LOAD: mod_freq_q <= (ld_idx_q == 5'(cfs_pkg::PW))
                                            ? prof_q[cfs_pkg::P_FLO] : mod_freq_q;
            default: if (done_evt) mod_freq_q <= prof_q[cfs_pkg::P_FFIN];
         endcase
      end
   end

   // Gain and flags follow the active phase, leaker sign the loaded profile
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mod_gain_q <= '0;
         mod_leak_q <= cfs_pkg::LEAK_ZERO;
         pd_flag_q <= 1'b0;
         lin_flag_q <= 1'b0;
      end else begin
         case (st_q)
            cfs_pkg::ST_UP, cfs_pkg::ST_HIGH:
               mod_gain_q <= prof_q[cfs_pkg::P_GHI][15:0];
            cfs_pkg::ST_DOWN, cfs_pkg::ST_LOW:
               mod_gain_q <= done_evt ? prof_q[cfs_pkg::P_GFIN][15:0]
                             : prof_q[cfs_pkg::P_GLO][15:0];
            default: if (done_evt) mod_gain_q <= prof_q[cfs_pkg::P_GFIN][15:0];
         endcase
         case (prof_q[cfs_pkg::P_LEAK][1:0])
            cfs_pkg::LEAK_POS: mod_leak_q <= cfs_pkg::LEAK_POS;
            cfs_pkg::LEAK_NEG: mod_leak_q <= cfs_pkg::LEAK_NEG;
            default: mod_leak_q <= cfs_pkg::LEAK_ZERO;
         endcase
         pd_flag_q <= st_q >= cfs_pkg::ST_UP && in_win(t_us_q, prof_q[cfs_pkg::P_PD]);
         lin_flag_q <= st_q >= cfs_pkg::ST_UP && in_win(t_us_q, prof_q[cfs_pkg::P_LIN]);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_trig_start: assert property (@(posedge clk) disable iff (!arst_n)
      (st_q == cfs_pkg::ST_IDLE && trig) |=> st_q == cfs_pkg::ST_LEAD)
      else $error("trigger did not start");
   a_busy_end: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(busy) |-> $past(done_evt)) else $error("busy dropped early");
   a_lead_first: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(busy) |-> st_q == cfs_pkg::ST_LEAD) else $error("no lead segment");
   a_period_lim: assert property (@(posedge clk) disable iff (!arst_n)
      busy && !ctrl_q[cfs_pkg::CTRL_INF] |-> per_q < 12'(MAXPER))
      else $error("period count overrun");
   a_clus_lim: assert property (@(posedge clk) disable iff (!arst_n)
      cidx_q < nclus_eff) else $error("cluster index overrun");
   a_skip_zero: assert property (@(posedge clk) disable iff (!arst_n)
      (st_q == cfs_pkg::ST_CLUS && cur_reps == 0) |=> st_q != cfs_pkg::ST_LOAD)
      else $error("empty cluster played");
   a_high_hold: assert property (@(posedge clk) disable iff (!arst_n)
      (st_q == cfs_pkg::ST_HIGH && $past(st_q) == cfs_pkg::ST_HIGH)
      |-> mod_freq_q == prof_q[cfs_pkg::P_FHI]
          && mod_gain_q == prof_q[cfs_pkg::P_GHI][15:0])
      else $error("high phase wrong");
   a_ramp_flag: assert property (@(posedge clk) disable iff (!arst_n)
      ramp_bad |=> irq_stat_q[cfs_pkg::IRQ_RAMP]) else $error("ramp error lost");
   a_busy_ign: assert property (@(posedge clk) disable iff (!arst_n)
      (busy && trig && st_q != cfs_pkg::ST_LEAD) |=> st_q != cfs_pkg::ST_LEAD)
      else $error("trigger restarted frame");
endmodule // cfs_seq

// ===== tb/cfs_far_end.sv
/* Far-end host model: trigger pin pulse and ramp meter samples.
 Assumes one clock shared with the sequencer. */
`timescale 1ns/100ps
module cfs_far_end (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic fire,
   input wire logic busy,
   input wire logic [31:0] meas_val,
   output logic sync_pin,
   output logic [31:0] ramp_meas,
   output logic ramp_meas_vld
);
   logic [2:0] cnt_q;
   logic [1:0] div_q;
   // Pin pulse length and meter pacing
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 3'h0;
         div_q <= 2'h0;
      end else begin
         cnt_q <= fire ? 3'h4 : cnt_q - {2'h0, cnt_q != 3'h0};
         div_q <= div_q + 2'h1;
      end
   end
   // Pin high for four cycles after each fire pulse
   assign sync_pin = cnt_q != 3'h0;
   // Meter sample every fourth cycle while the sequencer is busy
   assign ramp_meas_vld = busy && div_q == 2'h3;
   // Stale data inverted between samples
   assign ramp_meas = ramp_meas_vld ? meas_val : ~meas_val;
endmodule // cfs_far_end

// ===== tb/cfs_seq_test.sv
/* Bench for cfs_seq: bus tasks, two frames, interrupt checks.
 Assumes the far-end model in cfs_far_end.sv. */
`timescale 1ns/100ps
module cfs_seq_test;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [11:0] avs_address = 12'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic fire = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] meas_val = 32'h5;
   logic [31:0] avs_readdata, mod_freq_q, ramp_meas, rd;
   logic avs_waitrequest, busy, pd_flag_q, lin_flag_q, irq, sync_pin, ramp_meas_vld;
   logic [15:0] mod_gain_q;
   logic [1:0] mod_leak_q;
   int miscompares = 0;
   int samples_checked = 0;
   logic [1:0] flag_seen = 2'h0;
   // Sticky record of the two window flags
   always @(posedge clk) flag_seen <= flag_seen | {lin_flag_q, pd_flag_q};
   // 25 MHz clock
   always #20 clk = ~clk;
   cfs_seq cfs_seq_inst (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sync_pin(sync_pin), .ramp_meas(ramp_meas), .ramp_meas_vld(ramp_meas_vld),
      .busy(busy), .mod_freq_q(mod_freq_q), .mod_gain_q(mod_gain_q),
      .mod_leak_q(mod_leak_q), .pd_flag_q(pd_flag_q), .lin_flag_q(lin_flag_q), .irq(irq));
   cfs_far_end cfs_far_end_inst (.clk(clk), .arst_n(arst_n), .fire(fire), .busy(busy),
      .meas_val(meas_val), .sync_pin(sync_pin), .ramp_meas(ramp_meas),
      .ramp_meas_vld(ramp_meas_vld));
   // Verdict and end of run
   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h", $time, m, got);
      end
   endtask
   // One Avalon cycle, held until waitrequest is low
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      chk({31'h0, n >= 100}, 32'h0, "bus hang");
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string m);
      bus(1'b0, a, 32'h0);
      chk(rd, exp, m);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, busy}, 32'h0, "frame end");
   endtask
   // Profile word: short up ramp and high hold, flag windows, tagged values elsewhere
   function automatic logic [31:0] pw(input int p, input int w);
      if (w == cfs_pkg::P_PD) return 32'h0001_0000;
      if (w == cfs_pkg::P_LIN) return 32'h0002_0001;
      return (w >= cfs_pkg::P_DUP && w <= cfs_pkg::P_DLO)
         ? 32'(w == cfs_pkg::P_DUP || w == cfs_pkg::P_DHI) : 32'(256 * w + p);
   endfunction
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      rchk(cfs_pkg::A_CTRL, cfs_pkg::CTRL_RST, "ctrl reset");
      rchk(cfs_pkg::A_THR_HI, 32'hffff_ffff, "thr_hi reset");
      rchk(12'h0fc, 32'h0, "unmapped");
      for (int p = 0; p < 2; p++) begin
         for (int w = 0; w < 15; w++) begin
            bus(1'b1, cfs_pkg::A_PROF_BASE + 12'(4 * (p * cfs_pkg::PW + w)), pw(p, w));
         end
      end
      rchk(cfs_pkg::A_PROF_BASE + 12'(4 * (cfs_pkg::PW + 2)), 32'h201, "profile");
      bus(1'b1, cfs_pkg::A_CLUS_BASE, 32'h200);
      bus(1'b1, cfs_pkg::A_CLUS_BASE + 12'h4, 32'h0);
      bus(1'b1, cfs_pkg::A_CLUS_BASE + 12'h8, 32'h101);
      bus(1'b1, cfs_pkg::A_NCLUS, 32'h3);
      bus(1'b1, cfs_pkg::A_IRQ_MASK, 32'h1);
      bus(1'b1, cfs_pkg::A_CTRL, 32'h5);
      @(negedge clk);
      chk({31'h0, busy}, 32'h1, "busy after start");
      bus(1'b1, cfs_pkg::A_CTRL, 32'h5);
      wait_idle();
      chk(mod_freq_q, 32'h201, "final freq");
      chk({16'h0, mod_gain_q}, 32'hc01, "final gain");
      chk({30'h0, mod_leak_q}, 32'h1, "leaker sign");
      chk({30'h0, flag_seen}, 32'h3, "flag windows");
      chk({31'h0, irq}, 32'h1, "done irq");
      rchk(cfs_pkg::A_IRQ_STAT, 32'h5, "done and ignored");
      bus(1'b1, cfs_pkg::A_IRQ_STAT, 32'h7);
      rchk(cfs_pkg::A_IRQ_STAT, 32'h0, "stat clear");
      chk({31'h0, irq}, 32'h0, "irq clear");
      bus(1'b1, cfs_pkg::A_THR_HI, 32'h3);
      bus(1'b1, cfs_pkg::A_IRQ_MASK, 32'h2);
      bus(1'b1, cfs_pkg::A_PERIODS, 32'h2);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk({31'h0, busy}, 32'h1, "pin start");
      wait_idle();
      rchk(cfs_pkg::A_IRQ_STAT, 32'h3, "ramp error");
      chk({31'h0, irq}, 32'h1, "ramp irq");
      report_and_stop();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end
endmodule // cfs_seq_test
